//--- core/srwd_top.sv
// supervisor: reset pulse generator, watchdog and power-fail flag
`timescale 1ns/1ps
`default_nettype none
module srwd_top
  import srwd_pkg::*;
#(
  parameter logic [1:0]  VARIANT    = VARIANT_FULL,
  parameter int unsigned WDOG_TICKS = WDOG_CYCLES,
  parameter int unsigned RST_TICKS  = RESET_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic supply_low_in,
  input  wire logic manual_reset_n_in,
  input  wire logic manual_reset_undriven_in,
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_kick_undriven_in,
  input  wire logic powerfail_sense_in,
  output logic      reset_n_out,
  output logic      reset_out,
  output logic      watchdog_timeout_n_out,
  output logic      powerfail_flag_n_out
);
  // durations run as cycle counts of the free-running clock
  localparam logic [CNT_W-1:0] RST_LOAD  = CNT_W'(RST_TICKS);
  localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WDOG_TICKS - 1);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

  srwd_rst_state_t  state_q, state_d;
  logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic [CNT_W-1:0] wd_cnt_q;
  logic             wd_expired_q;
  logic             rst_asserted_q;
  logic             pf_n_q;
  logic             mr_n_raw;
  logic             mr_n_sync;
  logic             kick_sync;
  logic             kick_edge;
  logic             kick_float_q;
  logic             hold_cond;
  logic             wd_clear;
  logic             wd_present;
  logic             has_low_reset;
  logic             has_high_reset;

  // pull-up: an undriven manual reset line reads high
  assign mr_n_raw = manual_reset_n_in | manual_reset_undriven_in;

  srwd_sync #(.RESET_VAL(1'b1)) u_mr_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (mr_n_raw),
    .level_out  (mr_n_sync),
    .edge_out   ()
  );

  // kick edges only count once they have crossed both flops
  srwd_sync #(.RESET_VAL(1'b0)) u_kick_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (watchdog_kick_in),
    .level_out  (kick_sync),
    .edge_out   (kick_edge)
  );

  // reset held while supply low or manual reset low; watchdog has no say here
  assign hold_cond  = supply_low_in | !mr_n_sync;
  assign wd_present = (VARIANT != VARIANT_NO_WDOG);
  // named variant decodes keep the output muxes readable
  assign has_low_reset  = (VARIANT != VARIANT_HIGH_ONLY);
  assign has_high_reset = (VARIANT != VARIANT_FULL);

  // reset generator: hold, then count the pulse tail, then idle
  always_comb begin
    state_d   = state_q;
    rst_cnt_d = rst_cnt_q;
    case (state_q)
      SRWD_RST_HOLD: begin
        rst_cnt_d = RST_LOAD;
        if (!hold_cond) begin
          state_d = SRWD_RST_PULSE;
        end
      end
      SRWD_RST_PULSE: begin
        // a dip mid-pulse restarts the full tail, which exceeds 140 ms
        if (hold_cond) begin
          state_d = SRWD_RST_HOLD;
        end else if (rst_cnt_q <= CNT_ONE) begin
          state_d   = SRWD_RST_IDLE;
          rst_cnt_d = CNT_ZERO;
        end else begin
          rst_cnt_d = rst_cnt_q - CNT_ONE;
        end
      end
      SRWD_RST_IDLE: begin
        if (hold_cond) begin
          state_d = SRWD_RST_HOLD;
        end
      end
      default: begin
        state_d = SRWD_RST_HOLD;
      end
    endcase
  end

  // power-on starts in hold so reset is low from the first edge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q        <= SRWD_RST_HOLD;
      rst_cnt_q      <= CNT_ZERO;
      rst_asserted_q <= 1'b1;
    end else begin
      state_q        <= state_d;
      rst_cnt_q      <= rst_cnt_d;
      rst_asserted_q <= (state_d != SRWD_RST_IDLE);
    end
  end

  // watchdog clear sources; undriven kick keeps it disabled
  assign wd_clear = rst_asserted_q | watchdog_kick_undriven_in | kick_edge;

  // watchdog timer; counting starts once reset drops and kick is driven
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_cnt_q     <= CNT_ZERO;
      wd_expired_q <= 1'b0;
      kick_float_q <= 1'b1;
    end else begin
      kick_float_q <= watchdog_kick_undriven_in;
      if (wd_clear || !wd_present) begin
        wd_cnt_q     <= CNT_ZERO;
        wd_expired_q <= 1'b0;
      end else if (wd_cnt_q >= WDOG_LAST) begin
        wd_expired_q <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + CNT_ONE;
      end
    end
  end

  // power-fail flag registered, independent of everything else
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pf_n_q <= 1'b1;
    end else begin
      pf_n_q <= !powerfail_sense_in;
    end
  end

  // outputs by variant; supply low forces timeout low with no stretch
  assign watchdog_timeout_n_out = wd_present ?
      !(wd_expired_q | supply_low_in) : 1'b1;
  assign reset_n_out = has_low_reset ? !rst_asserted_q : 1'b1;
  assign reset_out   = has_high_reset ? rst_asserted_q : 1'b0;
  assign powerfail_flag_n_out = pf_n_q;

  // assertions
  sequence s_kick_quiet;
    !wd_clear && wd_present;
  endsequence

  // last tail cycle with no hold pending
  sequence s_pulse_last;
    state_q == SRWD_RST_PULSE && rst_cnt_q <= CNT_ONE && !hold_cond;
  endsequence

  // reset generator checks
  a_pulse_after_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state_q == SRWD_RST_HOLD && !hold_cond) |=> rst_asserted_q [*8])
    else $error("reset released too soon after hold");
  a_supply_holds_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      supply_low_in |=> rst_asserted_q)
    else $error("reset not asserted during low supply");
  a_manual_starts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      !mr_n_sync |=> state_q == SRWD_RST_HOLD)
    else $error("manual reset did not start pulse");
  a_no_wdog_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state_q == SRWD_RST_IDLE && !hold_cond && $rose(wd_expired_q)) |=>
      state_q == SRWD_RST_IDLE)
    else $error("timeout started reset");
  // tail end releases reset; a dip sends it back to hold
  a_pulse_ends: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      s_pulse_last |=> state_q == SRWD_RST_IDLE && !rst_asserted_q)
    else $error("reset pulse did not end");
  a_dip_restarts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state_q == SRWD_RST_PULSE && hold_cond) |=> state_q == SRWD_RST_HOLD && rst_asserted_q)
    else $error("dip during pulse did not restart hold");
  // the pull-up view must survive the synchroniser
  a_undriven_mr_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      manual_reset_undriven_in |=> ##1 mr_n_sync)
    else $error("undriven manual reset not seen high");

  // watchdog checks
  a_wd_clear_resets: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_clear |=> wd_cnt_q == CNT_ZERO && !wd_expired_q)
    else $error("watchdog not cleared");
  a_float_no_timeout: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (watchdog_kick_undriven_in && kick_float_q) |-> !wd_expired_q)
    else $error("timeout while kick undriven");
  a_expired_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (wd_expired_q && !wd_clear) |=> wd_expired_q)
    else $error("timeout dropped without clear");
  a_wd_counts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_kick_quiet ##0 (wd_cnt_q < WDOG_LAST)) |=> wd_cnt_q == $past(wd_cnt_q) + CNT_ONE)
    else $error("watchdog did not count");
  a_count_expires: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (wd_present && !wd_clear && wd_cnt_q >= WDOG_LAST) |=> wd_expired_q)
    else $error("full count did not raise timeout");

  // output checks
  a_supply_wdo: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (supply_low_in && wd_present) |-> !watchdog_timeout_n_out)
    else $error("timeout output high during low supply");
  a_expired_drives_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (wd_expired_q && wd_present) |-> !watchdog_timeout_n_out)
    else $error("timeout output high while expired");
  a_reset_complement: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (VARIANT == VARIANT_NO_WDOG) |-> reset_out == !reset_n_out)
    else $error("reset outputs not complementary");
  a_pf_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      1'b1 |=> powerfail_flag_n_out == !$past(powerfail_sense_in))
    else $error("power-fail flag wrong");
endmodule // srwd_top
`default_nettype wire

//--- core/srwd_pkg.sv
// constants shared by the supervisor reset and watchdog block
// What this block does
// - timeout output goes low after kick input sits 1.6 s without any edge.
// - watchdog count clears on system reset, undriven kick, and any kick edge.
// - undriven kick input disables the watchdog so no timeout can happen.
// - timeout output stays low until the watchdog count is next cleared.
// - low supply forces timeout output low, released at once on recovery.
// - once triggered, active-low reset output pulses low for 200 ms.
// - reset held while supply low, then 200 ms more after supply or manual release.
// - a watchdog timeout never starts a reset pulse by itself.
// - manual reset input sampled low starts a reset pulse.
// - undriven manual reset input counts as high because of its pull-up.
// - in the both-resets variant only, active-high reset output is the exact complement of active-low reset.
// - power-fail flag low while sense input is below threshold, else high.
// - build variant swaps watchdog and its output for an active-high reset.
// - build variant keeps watchdog but gives only the active-high reset output.
// - supply dip during a running reset pulse extends it at least 140 ms.
// - watchdog counts once reset is released and kick is actively driven.
package srwd_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned WDOG_TIMEOUT_MS  = 1600;  // 1.6 s
  localparam int unsigned RESET_PULSE_MS   = 200;
  localparam int unsigned BROWNOUT_EXT_MS  = 140;
  localparam int unsigned WDOG_CYCLES      = CLK_HZ / 1000 * WDOG_TIMEOUT_MS;
  localparam int unsigned RESET_CYCLES     = CLK_HZ / 1000 * RESET_PULSE_MS;
  localparam int unsigned CNT_W            = 27;
  localparam logic [1:0]  VARIANT_FULL     = 2'h0;  // watchdog + active-low reset
  localparam logic [1:0]  VARIANT_NO_WDOG  = 2'h1;  // both resets, no watchdog
  localparam logic [1:0]  VARIANT_HIGH_ONLY = 2'h2; // watchdog, active-high reset only
  typedef enum logic [1:0] {
    SRWD_RST_HOLD  = 2'b00,
    SRWD_RST_PULSE = 2'b01,
    SRWD_RST_IDLE  = 2'b10
  } srwd_rst_state_t;
endpackage : srwd_pkg

//--- core/srwd_sync.sv
// two-flop synchroniser with one-cycle edge outputs
`timescale 1ns/1ps
`default_nettype none
module srwd_sync
  import srwd_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      edge_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // meta_q feeds only sync_q; edges come from the settled pair
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
      last_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign edge_out  = sync_q ^ last_q;
endmodule // srwd_sync
`default_nettype wire

//--- tb/srwd_cpu_model.sv
// processor-side model: kicks the watchdog and can float the kick line
`timescale 1ns/1ps
`default_nettype none
module srwd_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       run_in,
  input  wire logic       float_in,
  input  wire logic [7:0] period_in,
  output logic            kick_out,
  output logic            undriven_out
);
  logic [7:0] gap_q;
  logic       float_q;
  // a released line flips once then sits still, so only the undriven flag
  // can keep the timer from running out while floating
  always @(posedge clk_in) begin
    #1;
    undriven_out = float_in;
    if (float_in) begin
      if (!float_q) begin
        kick_out = ~kick_out;
      end
      gap_q = 8'h00;
    end else if (run_in && reset_n_in && gap_q >= period_in) begin
      kick_out = ~kick_out;
      gap_q = 8'h00;
    end else begin
      gap_q = gap_q + 8'h01;
    end
    float_q = float_in;
  end
  // cpu held quiet until the bench lets it run
  initial begin
    kick_out = 1'b0;
    undriven_out = 1'b0;
    gap_q = 8'h00;
    float_q = 1'b0;
  end
endmodule // srwd_cpu_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the supervisor reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srwd_pkg::*;
  localparam int WD = 50;
  localparam int RT = 20;
  localparam logic [1:0] VAR = VARIANT_FULL;
  logic clk_in, reset_n_in, supply_low_in, manual_reset_n_in, manual_reset_undriven_in;
  logic powerfail_sense_in, run, flt, kick, kick_undriven, pf_b;
  logic reset_n_out, reset_out, wdo_n, pf_n;
  logic [7:0] period;
  logic [2:0] outs, last;
  logic [2:0] notes[$];
  int         failures, check_count, seed;
  srwd_top #(.VARIANT(VAR), .WDOG_TICKS(WD), .RST_TICKS(RT)) srwd_top_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .supply_low_in(supply_low_in),
    .manual_reset_n_in(manual_reset_n_in), .manual_reset_undriven_in(manual_reset_undriven_in),
    .watchdog_kick_in(kick), .watchdog_kick_undriven_in(kick_undriven),
    .powerfail_sense_in(powerfail_sense_in), .reset_n_out(reset_n_out), .reset_out(reset_out),
    .watchdog_timeout_n_out(wdo_n), .powerfail_flag_n_out(pf_n));
  srwd_cpu_model srwd_cpu_model_inst (.clk_in(clk_in), .reset_n_in(reset_n_out), .run_in(run),
    .float_in(flt), .period_in(period), .kick_out(kick), .undriven_out(kick_undriven));
  assign outs = {reset_n_out, wdo_n, pf_n};
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // count cycles until an output bit settles at a level, then judge the count
  task automatic wait_bit(input int idx, input logic v, input int lo, input int hi);
    int c;
    c = 0;
    while (outs[idx] !== v && c <= hi) begin
      @(negedge clk_in);
      c++;
    end
    check(c >= lo && c <= hi, 1'b1);
    tick(1);
  endtask
  // any output change must match the oldest note; unplanned changes fail
  always @(negedge clk_in) begin
    if (reset_n_in === 1'b1 && outs !== last) begin
      check(outs, (notes.size() == 0) ? last : notes.pop_front());
      check(reset_out, (VAR == VARIANT_FULL) ? 1'b0 : !reset_n_out);
    end
    last = outs;
  end
  initial begin
    seed = 32'h4AEF3DD9;
    failures = 0;
    check_count = 0;
    {reset_n_in, supply_low_in, manual_reset_undriven_in, powerfail_sense_in, run} = 5'h00;
    {manual_reset_n_in, flt, last, period} = {5'h1F, 8'h10};
    tick(5);
    reset_n_in = 1'b1;
    notes.push_back(3'h7);
    wait_bit(2, 1'b1, RT, RT + 5);
    $display("test power-on done");
    for (int i = 0; i < 4; i++) begin
      notes.push_back(3'h6);
      powerfail_sense_in = 1'b1;
      tick(1 + ($unsigned($random(seed)) % 8));
      notes.push_back(3'h7);
      powerfail_sense_in = 1'b0;
      tick(3);
    end
    // random sense levels; a note only where the flag must move
    for (int i = 0; i < 8; i++) begin
      pf_b = 1'($random(seed));
      if (pf_b !== powerfail_sense_in) notes.push_back({2'h3, !pf_b});
      powerfail_sense_in = pf_b;
      tick(2);
    end
    if (powerfail_sense_in) notes.push_back(3'h7);
    powerfail_sense_in = 1'b0;
    tick(2);
    $display("test power-fail done");
    flt = 1'b0;
    period = 8'(5 + ($unsigned($random(seed)) % 30));
    run = 1'b1;
    tick(300);
    @(kick);
    run = 1'b0;
    notes.push_back(3'h5);
    wait_bit(1, 1'b0, WD, WD + 6);
    tick(100);
    notes.push_back(3'h7);
    run = 1'b1;
    wait_bit(1, 1'b1, 0, 300);
    flt = 1'b1;
    run = 1'b0;
    tick(200);
    flt = 1'b0;
    run = 1'b1;
    $display("test watchdog done");
    manual_reset_undriven_in = 1'b1;
    repeat (50) begin
      manual_reset_n_in = 1'($random(seed));
      tick(1);
    end
    manual_reset_n_in = 1'b0;
    manual_reset_undriven_in = 1'b0;
    notes.push_back(3'h3);
    wait_bit(2, 1'b0, 1, 5);
    tick(3);
    manual_reset_n_in = 1'b1;
    notes.push_back(3'h7);
    wait_bit(2, 1'b1, RT, RT + 6);
    $display("test manual reset done");
    notes = {3'h5, 3'h1};
    supply_low_in = 1'b1;
    wait_bit(2, 1'b0, 1, 2);
    tick(30);
    notes = {3'h3, 3'h7};
    supply_low_in = 1'b0;
    wait_bit(2, 1'b1, RT, RT + 3);
    $display("test supply low done");
    notes = {3'h5, 3'h1, 3'h3};
    supply_low_in = 1'b1;
    tick(2);
    supply_low_in = 1'b0;
    tick(10);
    notes = {notes, 3'h1, 3'h3, 3'h7};
    supply_low_in = 1'b1;
    tick(1);
    supply_low_in = 1'b0;
    wait_bit(2, 1'b1, RT * 140 / 200, RT + 3);
    check(notes.size(), 0);
    $display("test brownout done");
    final_report();
  end
  // hang guard: the whole run needs about a thousand cycles
  initial begin
    #(20 * 20000);
    failures++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
